/* File: verilog/qpl_pkg.sv */
// Package for the per-slave-interface priority override and pending limit block.
// Assumes a single clk_sys domain and the plain register port of the top module.
package qpl_pkg;

  // ----------------------------------------------------------------------------
  // Register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------------------
  localparam logic [7:0] QPL_OFF_WR_PRIO_FORCE  = 8'h00;
  localparam logic [7:0] QPL_OFF_ATOMIC_CEIL    = 8'h04;
  localparam logic [7:0] QPL_OFF_READ_CEIL      = 8'h08;
  localparam logic [7:0] QPL_OFF_PRIO_CONTROL   = 8'h0c;
  localparam logic [7:0] QPL_OFF_SECURE_GATE    = 8'h10;
  localparam logic [7:0] QPL_OFF_REGULATOR      = 8'h14;
  localparam logic [7:0] QPL_OFF_PENDING_STATUS = 8'h18;
  localparam logic [7:0] QPL_IF_STRIDE          = 8'h20;

  // ----------------------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------------------
  localparam int QPL_PRIO_W        = 4;
  localparam int QPL_LIMIT_W       = 10;
  localparam int QPL_CTL_FORCE_BIT = 0;
  localparam int QPL_CTL_BQV_LO    = 4;
  localparam int QPL_CTL_BQV_HI    = 6;
  localparam int QPL_CTL_W         = 7;
  localparam int QPL_GATE_W        = 2;
  localparam int QPL_STAT_RD_LO    = 16;

  // ----------------------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------------------
  localparam logic [QPL_PRIO_W-1:0]  QPL_RST_PRIO      = 4'h0;
  localparam logic [QPL_LIMIT_W-1:0] QPL_RST_ATOMIC    = 10'h004;
  localparam logic [QPL_LIMIT_W-1:0] QPL_READ_MIN      = 10'h004;
  localparam logic [QPL_LIMIT_W-1:0] QPL_READ_DEPTH    = 10'h020;
  localparam logic [QPL_CTL_W-1:0]   QPL_RST_CTL       = 7'h00;
  localparam logic [QPL_GATE_W-1:0]  QPL_RST_GATE      = 2'h0;

  typedef logic [QPL_LIMIT_W-1:0] qpl_cnt_t;

endpackage : qpl_pkg

/* File: verilog/qpl_track_if.sv */
// Interface carrying one limit/counter pair between the top and a tracker.
// Assumes everything runs on clk_sys.
`timescale 1ns/1ps
interface qpl_track_if;
  import qpl_pkg::*;
  // Take and done say how many units join or leave in one cycle, 0 to 2.
  logic       regulate;
  qpl_cnt_t   limit;
  logic [1:0] take;
  logic [1:0] done;
  qpl_cnt_t   count;
  logic       at_limit;
  modport owner   (output regulate, output limit, output take, output done,
                   input count, input at_limit);
  modport tracker (input regulate, input limit, input take, input done,
                   output count, output at_limit);
endinterface : qpl_track_if

/* File: verilog/qpl_tracker.sv */
// Counts pending transactions of one type and flags when the ceiling is reached.
// Assumes take is only raised while at_limit is low or regulation is off.
`timescale 1ns/1ps
module qpl_tracker (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  qpl_track_if.tracker     trk
);
  import qpl_pkg::*;

  typedef struct packed {
    qpl_cnt_t count;
  } qpl_trk_s;

  qpl_trk_s st_r;
  qpl_trk_s st_nxt;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.count = st_r.count + qpl_cnt_t'(trk.take) - qpl_cnt_t'(trk.done);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign trk.count    = st_r.count;
  assign trk.at_limit = trk.regulate && (st_r.count >= trk.limit);

  a_count_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (trk.take != 2'b00 && trk.done == 2'b00)
    |=> (trk.count == $past(trk.count) + qpl_cnt_t'($past(trk.take))))
    else $error("pending count did not step up on a take");

endmodule : qpl_tracker

/* File: verilog/qpl_regs.sv */
// Per-slave-interface priority override and pending-transaction limit block.
// Assumes request and completion strobes come from logic on clk_sys; the
// override pin and secure attribute come from outside and are synchronised.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - Four-bit write priority override per interface.
// - Override applies when forced and no BQV.
// - Only secure accesses unless gate allows.
// - Separate override copy per built interface.
// - Ten-bit atomic ceiling enforced while regulating.
// - Each atomic AW request counts once.
// - Atomics also count as pending reads.
// - Ten-bit read ceiling enforced while regulating.
// - Oversize read ceiling stores built depth.
// - Read ceiling below four stores four.
module qpl_regs #(
  parameter int                      N_IF       = 2,
  parameter logic [N_IF-1:0]         HAS_FORCE  = '1,
  parameter logic [qpl_pkg::QPL_LIMIT_W-1:0] READ_DEPTH = qpl_pkg::QPL_READ_DEPTH
) (
  input  wire logic                              clk_sys,
  input  wire logic                              reset_n,
  input  wire logic [7:0]                        reg_addr,
  input  wire logic [31:0]                       reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  input  wire logic                              reg_secure,
  output      logic [31:0]                       reg_rdata,
  output      logic                              reg_denied,
  input  wire logic [N_IF-1:0]                   prio_force_input,
  input  wire logic [N_IF*qpl_pkg::QPL_PRIO_W-1:0] aw_qos_in,
  input  wire logic [N_IF-1:0]                   aw_atomic_valid,
  input  wire logic [N_IF-1:0]                   ar_valid,
  input  wire logic [N_IF-1:0]                   atomic_done,
  input  wire logic [N_IF-1:0]                   read_done,
  output      logic [N_IF*qpl_pkg::QPL_PRIO_W-1:0] aw_qos_out,
  output      logic [N_IF-1:0]                   aw_atomic_ready,
  output      logic [N_IF-1:0]                   ar_ready
);
  import qpl_pkg::*;

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [N_IF-1:0]                  force_m;
    logic [N_IF-1:0]                  force_s;
    logic                             sec_m;
    logic                             sec_s;
    logic [N_IF-1:0][QPL_PRIO_W-1:0]  wr_prio_force;
    logic [N_IF-1:0][QPL_LIMIT_W-1:0] atomic_ceil;
    logic [N_IF-1:0][QPL_LIMIT_W-1:0] read_ceil;
    logic [N_IF-1:0][QPL_CTL_W-1:0]   prio_ctl;
    logic [N_IF-1:0]                  regulate;
    logic [QPL_GATE_W-1:0]            gate;
    logic [31:0]                      rdata;
    logic                             denied;
    logic [N_IF-1:0][QPL_PRIO_W-1:0]  qos_out;
    logic [N_IF-1:0]                  at_rdy;
    logic [N_IF-1:0]                  ar_rdy;
  } qpl_state_s;

  qpl_state_s st_r;
  qpl_state_s st_nxt;
  logic [1:0] rst_sync_r;
  logic       rst_n;

  // Reset release through two flops; the assertion side is asynchronous.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------------------
  // Pending trackers
  // ----------------------------------------------------------------------------
  qpl_track_if at_trk [N_IF] ();
  qpl_track_if rd_trk [N_IF] ();
  logic [N_IF-1:0] at_full;
  logic [N_IF-1:0] rd_full;
  logic [N_IF-1:0] at_take;
  logic [N_IF-1:0] rd_take;
  logic [N_IF-1:0] ar_take;
  logic [N_IF-1:0][QPL_LIMIT_W-1:0] at_next;
  logic [N_IF-1:0][QPL_LIMIT_W-1:0] rd_next;

  for (genvar i = 0; i < N_IF; i++) begin : g_if
    assign at_take[i] = aw_atomic_valid[i] && st_r.at_rdy[i];
    assign ar_take[i] = ar_valid[i] && st_r.ar_rdy[i];
    // Atomics hold a read response slot, so they feed the read count too.
    assign rd_take[i] = ar_take[i] || at_take[i];
    assign at_trk[i].regulate = st_r.regulate[i];
    assign at_trk[i].limit    = st_r.atomic_ceil[i];
    assign at_trk[i].take     = {1'b0, at_take[i]};
    assign at_trk[i].done     = {1'b0, atomic_done[i]};
    assign rd_trk[i].regulate = st_r.regulate[i];
    assign rd_trk[i].limit    = st_r.read_ceil[i];
    // A read and an atomic taken together are two read units, not one.
    assign rd_trk[i].take     = {1'b0, ar_take[i]} + {1'b0, at_take[i]};
    assign rd_trk[i].done     = {1'b0, read_done[i]} + {1'b0, atomic_done[i]};
    assign at_full[i]         = at_trk[i].at_limit;
    assign rd_full[i]         = rd_trk[i].at_limit;
    assign at_next[i]         = at_trk[i].count + qpl_cnt_t'(at_trk[i].take)
                                - qpl_cnt_t'(at_trk[i].done);
    assign rd_next[i]         = rd_trk[i].count + qpl_cnt_t'(rd_trk[i].take)
                                - qpl_cnt_t'(rd_trk[i].done);

    qpl_tracker u_at (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .trk     (at_trk[i])
    );
    qpl_tracker u_rd (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .trk     (rd_trk[i])
    );
  end

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic [QPL_LIMIT_W-1:0] clamp_read(input logic [31:0] v);
    logic [QPL_LIMIT_W-1:0] lim;
    lim = v[QPL_LIMIT_W-1:0];
    if (v[31:QPL_LIMIT_W] != '0 || lim > READ_DEPTH) begin
      lim = READ_DEPTH;
    end else if (lim < QPL_READ_MIN) begin
      lim = QPL_READ_MIN;
    end
    return lim;
  endfunction : clamp_read

  function automatic logic [31:0] widen(input logic [QPL_LIMIT_W-1:0] v);
    return {{(32-QPL_LIMIT_W){1'b0}}, v};
  endfunction : widen

  // Only an interface whose override copy was built exposes that register.
  logic       allowed;
  logic [7:0] reg_off;
  int unsigned reg_if;
  assign allowed = st_r.sec_s || (st_r.gate != '0);
  assign reg_off = reg_addr & (QPL_IF_STRIDE - 8'h01);
  assign reg_if  = 32'(reg_addr / QPL_IF_STRIDE);

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.force_m  = prio_force_input;
    st_nxt.force_s  = st_r.force_m;
    st_nxt.sec_m    = reg_secure;
    st_nxt.sec_s    = st_r.sec_m;
    st_nxt.rdata    = 32'h0000_0000;
    st_nxt.denied   = 1'b0;

    if ((reg_wr || reg_rd) && !allowed) begin
      st_nxt.denied = 1'b1;
    end else if (reg_wr && reg_off == QPL_OFF_SECURE_GATE && reg_if == 0) begin
      st_nxt.gate = reg_wdata[QPL_GATE_W-1:0];
    end else if (reg_wr && reg_if < N_IF) begin
      case (reg_off)
        QPL_OFF_WR_PRIO_FORCE: begin
          if (HAS_FORCE[reg_if]) begin
            st_nxt.wr_prio_force[reg_if] = reg_wdata[QPL_PRIO_W-1:0];
          end
        end
        QPL_OFF_ATOMIC_CEIL: st_nxt.atomic_ceil[reg_if] = reg_wdata[QPL_LIMIT_W-1:0];
        QPL_OFF_READ_CEIL:   st_nxt.read_ceil[reg_if] = clamp_read(reg_wdata);
        QPL_OFF_PRIO_CONTROL: st_nxt.prio_ctl[reg_if] = reg_wdata[QPL_CTL_W-1:0];
        QPL_OFF_REGULATOR:   st_nxt.regulate[reg_if] = reg_wdata[0];
        default: st_nxt.denied = 1'b0;
      endcase
    end else if (reg_rd && reg_off == QPL_OFF_SECURE_GATE && reg_if == 0) begin
      st_nxt.rdata = {30'h0, st_r.gate};
    end else if (reg_rd && reg_if < N_IF) begin
      case (reg_off)
        QPL_OFF_WR_PRIO_FORCE: begin
          if (HAS_FORCE[reg_if]) begin
            st_nxt.rdata = {28'h0, st_r.wr_prio_force[reg_if]};
          end
        end
        QPL_OFF_ATOMIC_CEIL:  st_nxt.rdata = widen(st_r.atomic_ceil[reg_if]);
        QPL_OFF_READ_CEIL:    st_nxt.rdata = widen(st_r.read_ceil[reg_if]);
        QPL_OFF_PRIO_CONTROL: st_nxt.rdata = {25'h0, st_r.prio_ctl[reg_if]};
        QPL_OFF_REGULATOR:    st_nxt.rdata = {31'h0, st_r.regulate[reg_if]};
        QPL_OFF_PENDING_STATUS: begin
          st_nxt.rdata = (widen(rd_trk[0].count) << QPL_STAT_RD_LO);
          st_nxt.rdata = 32'h0;
        end
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    for (int i = 0; i < N_IF; i++) begin
      if (HAS_FORCE[i] && (st_r.force_s[i] || st_r.prio_ctl[i][QPL_CTL_FORCE_BIT])
          && (st_r.prio_ctl[i][QPL_CTL_BQV_HI:QPL_CTL_BQV_LO] == '0)) begin
        st_nxt.qos_out[i] = st_r.wr_prio_force[i];
      end else begin
        st_nxt.qos_out[i] = aw_qos_in[i*QPL_PRIO_W +: QPL_PRIO_W];
      end
      // Ready is judged on next cycle's counts and settings, so no take can
      // overrun. An atomic needs two free read slots, since a read may be
      // taken beside it in the same cycle.
      st_nxt.at_rdy[i] = !(st_nxt.regulate[i] &&
        (at_next[i] >= st_nxt.atomic_ceil[i] ||
         rd_next[i] >= st_nxt.read_ceil[i] - 10'h001));
      st_nxt.ar_rdy[i] = !(st_nxt.regulate[i] &&
        rd_next[i] >= st_nxt.read_ceil[i]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r.force_m       <= '0;
      st_r.force_s       <= '0;
      st_r.sec_m         <= 1'b0;
      st_r.sec_s         <= 1'b0;
      st_r.wr_prio_force <= '0;
      st_r.atomic_ceil   <= {N_IF{QPL_RST_ATOMIC}};
      st_r.read_ceil     <= {N_IF{READ_DEPTH}};
      st_r.prio_ctl      <= '0;
      st_r.regulate      <= '0;
      st_r.gate          <= QPL_RST_GATE;
      st_r.rdata         <= 32'h0000_0000;
      st_r.denied        <= 1'b0;
      st_r.qos_out       <= '0;
      st_r.at_rdy        <= '0;
      st_r.ar_rdy        <= '0;
    end else begin
      st_r.force_m       <= st_nxt.force_m;
      st_r.force_s       <= st_nxt.force_s;
      st_r.sec_m         <= st_nxt.sec_m;
      st_r.sec_s         <= st_nxt.sec_s;
      st_r.wr_prio_force <= st_nxt.wr_prio_force;
      st_r.atomic_ceil   <= st_nxt.atomic_ceil;
      st_r.read_ceil     <= st_nxt.read_ceil;
      st_r.prio_ctl      <= st_nxt.prio_ctl;
      st_r.regulate      <= st_nxt.regulate;
      st_r.gate          <= st_nxt.gate;
      st_r.rdata         <= st_nxt.rdata;
      st_r.denied        <= st_nxt.denied;
      st_r.qos_out       <= st_nxt.qos_out;
      st_r.at_rdy        <= st_nxt.at_rdy;
      st_r.ar_rdy        <= st_nxt.ar_rdy;
    end
  end

  assign reg_rdata       = st_r.rdata;
  assign reg_denied      = st_r.denied;
  assign aw_qos_out      = st_r.qos_out;
  assign aw_atomic_ready = st_r.at_rdy;
  assign ar_ready        = st_r.ar_rdy;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  sequence s_ceil_write;
    reg_wr && allowed && reg_off == QPL_OFF_READ_CEIL && reg_if == 0;
  endsequence

  a_read_ceil_floor: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_ceil_write ##0 (reg_wdata < 32'd4) |=> (st_r.read_ceil[0] == QPL_READ_MIN))
    else $error("read ceiling below minimum was not raised");

  a_read_ceil_top: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_ceil_write ##0 (reg_wdata > 32'(READ_DEPTH)) |=> (st_r.read_ceil[0] == READ_DEPTH))
    else $error("read ceiling above depth was not capped");

  a_secure_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && !allowed) |=> (reg_denied && $stable(st_r.atomic_ceil)))
    else $error("non-secure write was not refused");

  a_prio_force: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (HAS_FORCE[0] && st_r.prio_ctl[0][QPL_CTL_FORCE_BIT] &&
     st_r.prio_ctl[0][QPL_CTL_BQV_HI:QPL_CTL_BQV_LO] == '0 && $stable(st_r.prio_ctl[0]))
    |=> (aw_qos_out[QPL_PRIO_W-1:0] == $past(st_r.wr_prio_force[0])))
    else $error("write priority override not applied");

  a_prio_bqv_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r.prio_ctl[0][QPL_CTL_BQV_HI:QPL_CTL_BQV_LO] != '0)
    |=> (aw_qos_out[QPL_PRIO_W-1:0] == $past(aw_qos_in[QPL_PRIO_W-1:0])))
    else $error("override applied while regulation enabled");

  a_prio_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (HAS_FORCE[0] && reg_wr && allowed && reg_off == QPL_OFF_WR_PRIO_FORCE && reg_if == 0)
    |=> (st_r.wr_prio_force[0] == $past(reg_wdata[QPL_PRIO_W-1:0])))
    else $error("write priority override not stored");

  a_atomic_cap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r.regulate[0] && $stable(st_r.regulate[0]) && $stable(st_r.atomic_ceil[0]))
    |-> (at_trk[0].count <= st_r.atomic_ceil[0] || !at_take[0]))
    else $error("atomic pending count passed its ceiling");

  a_atomic_reads: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (at_take[0] && !read_done[0] && !atomic_done[0])
    |=> (rd_trk[0].count ==
         $past(rd_trk[0].count) + 10'h001 + qpl_cnt_t'($past(ar_take[0]))))
    else $error("atomic not counted as pending read");

  a_read_stall: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r.regulate[0] && rd_full[0]) |-> !rd_take[0])
    else $error("read accepted at its ceiling");

  a_atomic_stall: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r.regulate[0] && at_full[0]) |-> !at_take[0])
    else $error("atomic accepted at its ceiling");

  a_atomic_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (at_take[0] && !atomic_done[0])
    |=> (at_trk[0].count == $past(at_trk[0].count) + 10'h001))
    else $error("atomic request not counted once");

  a_regoff_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!st_r.regulate[0] && !reg_wr) |=> ar_ready[0])
    else $error("read stalled while regulation is off");

  a_read_ceil_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_ceil_write ##0 (reg_wdata >= 32'h4 && reg_wdata <= 32'(READ_DEPTH))
    |=> (st_r.read_ceil[0] == $past(reg_wdata[QPL_LIMIT_W-1:0])))
    else $error("legal read ceiling not stored as written");

  sequence s_prio_read;
    reg_rd && allowed && reg_off == QPL_OFF_WR_PRIO_FORCE && reg_if == 0;
  endsequence

  a_prio_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_prio_read |=> (reg_rdata[31:QPL_PRIO_W] == '0))
    else $error("reserved priority bits read as nonzero");

  a_prio_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!st_r.force_s[0] && !st_r.prio_ctl[0][QPL_CTL_FORCE_BIT])
    |=> (aw_qos_out[QPL_PRIO_W-1:0] == $past(aw_qos_in[QPL_PRIO_W-1:0])))
    else $error("write priority replaced without a force request");

  a_denied_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(reg_wr || reg_rd) |=> !reg_denied)
    else $error("refusal flagged with no access");

endmodule : qpl_regs

/* File: sim/qpl_mgr_model.sv */
// Behavioural upstream manager that issues reads and atomics into the block.
// Assumes the bench asks for traffic and completions on clk_sys.
`timescale 1ns/1ps
module qpl_mgr_model #(
  parameter int N_IF = 2
) (
  input  wire logic            clk_sys,
  input  wire logic            reset_n,
  input  wire logic [N_IF-1:0] want_rd,
  input  wire logic [N_IF-1:0] want_at,
  input  wire logic [N_IF-1:0] ret_rd,
  input  wire logic [N_IF-1:0] ret_at,
  input  wire logic [N_IF-1:0] ar_ready,
  input  wire logic [N_IF-1:0] aw_atomic_ready,
  output      logic [N_IF-1:0] ar_valid,
  output      logic [N_IF-1:0] aw_atomic_valid,
  output      logic [N_IF-1:0] read_done,
  output      logic [N_IF-1:0] atomic_done,
  output      logic [7:0]      rd_taken [N_IF],
  output      logic [7:0]      at_taken [N_IF]
);
  // A request, once raised, stays up until it is taken, as a real manager must.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ar_valid        <= '0;
      aw_atomic_valid <= '0;
      read_done       <= '0;
      atomic_done     <= '0;
      for (int i = 0; i < N_IF; i++) begin
        rd_taken[i] <= '0;
        at_taken[i] <= '0;
      end
    end else begin
      ar_valid        <= want_rd | (ar_valid & ~ar_ready);
      aw_atomic_valid <= want_at | (aw_atomic_valid & ~aw_atomic_ready);
      read_done       <= ret_rd;
      atomic_done     <= ret_at;
      for (int i = 0; i < N_IF; i++) begin
        rd_taken[i] <= rd_taken[i] + 8'(ar_valid[i] & ar_ready[i]);
        at_taken[i] <= at_taken[i] + 8'(aw_atomic_valid[i] & aw_atomic_ready[i]);
      end
    end
  end
endmodule : qpl_mgr_model

/* File: sim/qpl_regs_bench.sv */
// Self-checking bench for the priority override and pending limit block.
// Assumes qpl_pkg, qpl_regs and the manager model are compiled before it.
`timescale 1ns/1ps
module qpl_regs_bench;
  import qpl_pkg::*;
  localparam int N_IF = 2;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] golden;
  } qpl_row_s;
  // ---------------------------------------------------------------------------
  // Stimulus tables
  // ---------------------------------------------------------------------------
  localparam qpl_row_s ROWS [14] = '{
    '{1'b0, 8'h00, 32'h0, {28'h0, QPL_RST_PRIO}},
    '{1'b0, 8'h04, 32'h0, {22'h0, QPL_RST_ATOMIC}},
    '{1'b0, 8'h08, 32'h0, {22'h0, QPL_READ_DEPTH}},
    '{1'b1, 8'h00, 32'hffff_ffff, 32'h0000_000f},
    '{1'b1, 8'h04, 32'hffff_ffff, 32'h0000_03ff},
    '{1'b1, 8'h08, 32'h0000_0002, 32'h0000_0004},
    '{1'b1, 8'h08, 32'h0000_0003, 32'h0000_0004},
    '{1'b1, 8'h08, 32'h0000_0004, 32'h0000_0004},
    '{1'b1, 8'h08, 32'h0000_0021, 32'h0000_0020},
    '{1'b1, 8'h08, 32'h0000_0420, 32'h0000_0020},
    '{1'b1, 8'h08, 32'h0000_0011, 32'h0000_0011},
    '{1'b1, 8'h28, 32'h0000_0000, 32'h0000_0004},
    '{1'b1, 8'h20, 32'h0000_0005, 32'h0000_0000},
    '{1'b1, 8'h1c, 32'h0000_0001, 32'h0000_0000}
  };
  localparam logic [7:0] FRC_CTL [8] = '{8'h00, 8'h01, 8'h11, 8'h21, 8'h41, 8'h00, 8'h20, 8'h0e};
  localparam logic [7:0] FRC_PIN = 8'b1110_0000;
  localparam logic [7:0] FRC_HIT = 8'b1010_0010;
  logic                 clk_sys = 1'b0;
  logic                 reset_n = 1'b0;
  logic [7:0]           reg_addr = '0;
  logic [31:0]          reg_wdata = '0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic                 reg_secure = 1'b1;
  logic [31:0]          reg_rdata;
  logic                 reg_denied;
  logic [N_IF-1:0]      prio_force_input = '0;
  logic [N_IF-1:0]      want_rd = '0;
  logic [N_IF-1:0]      want_at = '0;
  logic [N_IF-1:0]      ret_rd = '0;
  logic [N_IF-1:0]      ret_at = '0;
  logic [N_IF*4-1:0]    aw_qos_in = '0;
  logic [N_IF*4-1:0]    aw_qos_out;
  logic [N_IF-1:0]      aw_atomic_valid, ar_valid, atomic_done, read_done;
  logic [N_IF-1:0]      aw_atomic_ready, ar_ready;
  logic [7:0]           rd_taken [N_IF];
  logic [7:0]           at_taken [N_IF];
  logic [31:0]          rd_val;
  logic                 den_val;
  int                   n_mismatch = 0;
  int                   compares = 0;

  always #2 clk_sys = ~clk_sys;

  qpl_regs #(.N_IF(N_IF), .HAS_FORCE(2'b01), .READ_DEPTH(QPL_READ_DEPTH)) i_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_secure(reg_secure), .reg_rdata(reg_rdata),
    .reg_denied(reg_denied), .prio_force_input(prio_force_input), .aw_qos_in(aw_qos_in),
    .aw_atomic_valid(aw_atomic_valid), .ar_valid(ar_valid), .atomic_done(atomic_done),
    .read_done(read_done), .aw_qos_out(aw_qos_out), .aw_atomic_ready(aw_atomic_ready),
    .ar_ready(ar_ready));
  qpl_mgr_model #(.N_IF(N_IF)) i_mgr (
    .clk_sys(clk_sys), .reset_n(reset_n), .want_rd(want_rd), .want_at(want_at),
    .ret_rd(ret_rd), .ret_at(ret_at), .ar_ready(ar_ready), .aw_atomic_ready(aw_atomic_ready),
    .ar_valid(ar_valid), .aw_atomic_valid(aw_atomic_valid), .read_done(read_done),
    .atomic_done(atomic_done), .rd_taken(rd_taken), .at_taken(at_taken));
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] golden);
    compares++;
    if (seen !== golden) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, golden);
    end
  endtask : check
  // One register access; the answer is caught in the single cycle it stands.
  task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= wr;
    reg_rd    <= !wr;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    rd_val  = reg_rdata;
    den_val = reg_denied;
    @(posedge clk_sys);
  endtask : reg_acc
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : ticks
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    ticks(20000);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    ticks(5);
    reset_n <= 1'b1;
    ticks(5);
    foreach (ROWS[k]) begin
      if (ROWS[k].wr) reg_acc(1'b1, ROWS[k].addr, ROWS[k].wdata);
      reg_acc(1'b0, ROWS[k].addr, 32'h0);
      check(rd_val, ROWS[k].golden);
    end
    reg_secure <= 1'b0;
    ticks(4);
    reg_acc(1'b1, QPL_OFF_WR_PRIO_FORCE, 32'h7);
    check({31'h0, den_val}, 32'h1);
    reg_acc(1'b0, QPL_OFF_WR_PRIO_FORCE, 32'h0);
    check({den_val, rd_val[30:0]}, 32'h8000_0000);
    reg_secure <= 1'b1;
    ticks(4);
    reg_acc(1'b0, QPL_OFF_WR_PRIO_FORCE, 32'h0);
    check(rd_val, 32'hf);
    reg_acc(1'b1, QPL_OFF_SECURE_GATE, 32'h2);
    reg_secure <= 1'b0;
    ticks(4);
    reg_acc(1'b1, QPL_OFF_WR_PRIO_FORCE, 32'ha);
    reg_acc(1'b0, QPL_OFF_WR_PRIO_FORCE, 32'h0);
    check(rd_val, 32'ha);
    reg_acc(1'b1, QPL_OFF_SECURE_GATE, 32'h0);
    reg_secure <= 1'b1;
    ticks(4);
    aw_qos_in <= 8'h53;
    for (int k = 0; k < 8; k++) begin
      prio_force_input <= {1'b0, FRC_PIN[k]};
      reg_acc(1'b1, QPL_OFF_PRIO_CONTROL, {24'h0, FRC_CTL[k]});
      ticks(4);
      #1;
      check({24'h0, aw_qos_out}, {24'h0, 4'h5, FRC_HIT[k] ? 4'ha : 4'h3});
    end
    prio_force_input <= '0;
    reg_acc(1'b1, QPL_OFF_PRIO_CONTROL, 32'h0);
    reg_acc(1'b1, QPL_OFF_ATOMIC_CEIL, 32'h2);
    reg_acc(1'b1, QPL_OFF_READ_CEIL, 32'h4);
    reg_acc(1'b1, QPL_OFF_REGULATOR, 32'h1);
    reg_acc(1'b1, QPL_IF_STRIDE + QPL_OFF_READ_CEIL, 32'h4);
    want_at <= 2'b01;
    ticks(20);
    #1;
    check({24'h0, at_taken[0]}, 32'h2);
    want_rd <= 2'b11;
    ticks(20);
    #1;
    check({24'h0, rd_taken[0]}, 32'h2);
    check({31'h0, rd_taken[1] > 8'd4}, 32'h1);
    ret_at <= 2'b01;
    ticks(1);
    ret_at <= 2'b00;
    ticks(20);
    #1;
    check({24'h0, at_taken[0] + rd_taken[0]}, 32'h5);
    ret_rd <= 2'b01;
    ticks(1);
    ret_rd <= 2'b00;
    ticks(20);
    #1;
    check({24'h0, at_taken[0] + rd_taken[0]}, 32'h6);
    want_rd <= '0;
    want_at <= '0;
    ticks(4);
    reset_n <= 1'b0;
    ticks(2);
    #1;
    check({28'h0, ar_ready, aw_atomic_ready}, 32'h0);
    reset_n <= 1'b1;
    ticks(5);
    reg_acc(1'b0, QPL_OFF_READ_CEIL, 32'h0);
    check(rd_val, {22'h0, QPL_READ_DEPTH});
    report_and_stop();
  end
endmodule : qpl_regs_bench
